//--- core/pcs_pkg.sv
// constants shared by the program counter and hardware stack block
package pcs_pkg;

   // program counter and program memory geometry
   localparam int PCS_AW = 11;
   localparam int PCS_IW = 16;
   localparam int PCS_WORDS = 2048;
   localparam logic [10:0] PCS_PC_TOP = 11'h07ff;
   localparam logic [10:0] PCS_PC_RESET = 11'h000;
   localparam logic [15:0] PCS_BLANK_WORD = 16'hffff;

   // stack geometry: pointer 0 is empty, 1..7 are layers
   localparam int PCS_DEPTH = 7;
   localparam logic [2:0] PCS_SP_EMPTY = 3'h0;
   localparam logic [2:0] PCS_SP_TOP = 3'h7;
   localparam logic [2:0] PCS_SP_WARN = 3'h6;

   // register byte addresses on the bus, one aligned word each
   localparam logic [7:0] PCS_ADR_PC_HIGH = 8'h00;
   localparam logic [7:0] PCS_ADR_PC_LOW = 8'h04;
   localparam logic [7:0] PCS_ADR_TOP_HIGH = 8'h08;
   localparam logic [7:0] PCS_ADR_TOP_LOW = 8'h0c;
   localparam logic [7:0] PCS_ADR_CONTROL = 8'h10;
   localparam logic [7:0] PCS_ADR_STATUS = 8'h14;

   // field positions
   localparam int PCS_BIT_FULL = 7;
   localparam int PCS_BIT_UNDER = 6;
   localparam int PCS_BIT_OVER = 5;
   localparam int PCS_BIT_ERROR = 2;

   // reset values
   localparam logic [2:0] PCS_LATCH_RESET = 3'h0;
   localparam logic [31:0] PCS_DATA_RESET = 32'h0000_0000;

endpackage

//--- core/pcs_core.sv
// program counter, hardware return stack and program memory of the core
// Functional notes
// [RULE1] program space is words 0 to 0x7ff, 2048 words, 11-bit counter
// [RULE2] unprogrammed words read all ones; programmed words read as written
// [RULE3] counter high bits reached only through the high latch register
// [RULE4] software reads low latch byte first, then high latch bits
// [RULE5] software writes high latch bits first, then low latch byte
// [RULE6] stack top is 11 bits; reads zero when pointer is zero
// [RULE7] call or interrupt: pointer plus one, current address pushed
// [RULE8] return: stack top into counter, then pointer minus one
// [RULE9] stack top registers readable any time in any order
// [RULE10] pop discards the top, pointer minus one, new layer shown
// [RULE11] each layer holds an address; selected layer appears as top
// [RULE12] full flag warns before overflow and leaves counter alone
// [RULE13] pop at pointer zero gives no underflow, pointer stays zero
// [RULE14] underflow: flag, counter and pointer to zero, optional reset
// [RULE15] overflow: flag, pointer stays at last layer, push overwrites
// [RULE16] error reset enable is a build-time strap, not software visible
// [RULE17] error flag marks a stack error; error reset clears under/over
// [RULE18] full, overflow and underflow may all stand set together
// [RULE19] after overflow pushes overwrite top; a pop clears overflow
// [RULE20] pointer is the binary layer number, zero meaning empty
// [RULE21] stack flags stay set until pop, software clear or reset
// [RULE22] counter steps by one per fetch and wraps in 11 bits
//
// Implementation choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ns

module pcs_core
   import pcs_pkg::*;
(
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [3:0] wb_sel_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   input wire logic fetch_in,
   input wire logic push_in,
   input wire logic [10:0] push_target_in,
   input wire logic ret_in,
   input wire logic pop_in,
   input wire logic stack_error_reset_enable_in,
   input wire logic prog_we_in,
   input wire logic [10:0] prog_addr_in,
   input wire logic [15:0] prog_data_in,
   output logic [10:0] pc_out,
   output logic [15:0] instr_out,
   output logic chip_reset_out
);

   // pointer step, shared by push, return and pop paths
   function automatic logic [2:0] pcs_step(input logic [2:0] v, input logic up);
      logic [2:0] r;
      r = up ? v + 3'h1 : v - 3'h1;
      return r;
   endfunction

   logic [10:0] pc;
   logic [2:0] sp;
   logic [10:0] layer [1:PCS_DEPTH];
   logic [2:0] pc_latch_high;
   logic stack_full_flag;
   logic stack_overflow_flag;
   logic stack_underflow_flag;
   logic stack_error_flag;
   logic stack_error_reset_enable;
   logic strap_taken;
   logic [PCS_IW-1:0] main_program_memory [0:PCS_WORDS-1];
   logic [PCS_WORDS-1:0] prog_done;
   logic [10:0] next_pc;
   logic [2:0] next_sp;

   // bus request decode; a request is taken once, in the cycle before ack
   wire bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire bus_wr = bus_req & wb_we_in & wb_sel_in[0];
   wire bus_rd = bus_req & ~wb_we_in;
   wire hit_pch = wb_adr_in == PCS_ADR_PC_HIGH;
   wire hit_pcl = wb_adr_in == PCS_ADR_PC_LOW;
   wire hit_tsh = wb_adr_in == PCS_ADR_TOP_HIGH;
   wire hit_tsl = wb_adr_in == PCS_ADR_TOP_LOW;
   wire hit_ctl = wb_adr_in == PCS_ADR_CONTROL;
   wire hit_sts = wb_adr_in == PCS_ADR_STATUS;
   wire wr_pch = bus_wr & hit_pch;
   wire wr_pcl = bus_wr & hit_pcl;
   wire wr_ctl = bus_wr & hit_ctl;
   wire wr_sts = bus_wr & hit_sts;
   wire rd_pcl = bus_rd & hit_pcl;

   // selected layer drives the top; empty stack reads zero
   wire sp_empty = sp == PCS_SP_EMPTY;
   wire sp_at_top = sp == PCS_SP_TOP;
   wire [10:0] stack_top = sp_empty ? PCS_PC_RESET : layer[sp]; // [RULE6] [RULE11]

   // one stack operation per cycle: return, then push, then pop
   wire do_ret = ret_in;
   wire do_push = push_in & ~ret_in;
   wire do_pop = pop_in & ~ret_in & ~push_in;
   wire underflow_ev = do_ret & sp_empty; // [RULE14]
   wire overflow_ev = do_push & sp_at_top; // [RULE15]
   wire error_ev = underflow_ev | overflow_ev;
   wire err_rst = error_ev & stack_error_reset_enable; // [RULE14] [RULE15]
   wire pop_eff = do_pop & ~sp_empty; // [RULE13]
   wire set_full = do_push & (sp == PCS_SP_WARN); // [RULE12]

   // software clears flags by writing ones; a setting event wins
   wire clr_full = wr_ctl & wb_dat_in[PCS_BIT_FULL];
   wire clr_under = wr_ctl & wb_dat_in[PCS_BIT_UNDER];
   wire clr_over = wr_ctl & wb_dat_in[PCS_BIT_OVER];
   wire clr_error = wr_sts & wb_dat_in[PCS_BIT_ERROR];

   // read data mux, reserved bits read zero
   wire [7:0] rd_byte =
      hit_pch ? {5'h00, pc_latch_high} :
      hit_pcl ? pc[7:0] :
      hit_tsh ? {5'h00, stack_top[10:8]} :
      hit_tsl ? stack_top[7:0] :
      hit_ctl ? {stack_full_flag, stack_underflow_flag, stack_overflow_flag, 2'h0, sp} :
      hit_sts ? {5'h00, stack_error_flag, 2'h0} :
      8'h00;

   // next counter: underflow or error reset beats return, push, bus load and fetch
   always_comb begin
      next_pc = pc;
      if (err_rst || underflow_ev) begin
         next_pc = PCS_PC_RESET; // [RULE14]
      end else if (do_ret) begin
         next_pc = stack_top; // [RULE8]
      end else if (do_push) begin
         next_pc = push_target_in; // [RULE12] [RULE15]
      end else if (wr_pcl) begin
         next_pc = {pc_latch_high, wb_dat_in[7:0]}; // [RULE3] [RULE5]
      end else if (fetch_in) begin
         next_pc = pc + 11'h001; // [RULE1] [RULE22]
      end
   end

   // next pointer, saturating at the last layer and at empty
   always_comb begin
      next_sp = sp;
      if (err_rst || underflow_ev) begin
         next_sp = PCS_SP_EMPTY; // [RULE14]
      end else if (do_ret) begin
         next_sp = pcs_step(sp, 1'b0); // [RULE8]
      end else if (do_push && !sp_at_top) begin
         next_sp = pcs_step(sp, 1'b1); // [RULE7] [RULE20]
      end else if (pop_eff) begin
         next_sp = pcs_step(sp, 1'b0); // [RULE10]
      end
   end

   // counter and pointer registers
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pc <= PCS_PC_RESET;
         sp <= PCS_SP_EMPTY;
      end else if (ce_in) begin
         pc <= next_pc;
         sp <= next_sp;
      end
   end

   assign pc_out = pc;

   // layer storage needs no reset: the pointer guards every read
   always_ff @(posedge core_clk_in) begin
      if (ce_in && do_push && !err_rst) begin
         // at the last layer the push overwrites the newest entry
         layer[sp_at_top ? PCS_SP_TOP : pcs_step(sp, 1'b1)] <= pc; // [RULE7] [RULE19]
      end
   end

   // high latch: written by software, refreshed by each low byte read
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pc_latch_high <= PCS_LATCH_RESET;
      end else if (ce_in) begin
         if (wr_pch) begin
            pc_latch_high <= wb_dat_in[2:0]; // [RULE5]
         end else if (rd_pcl) begin
            pc_latch_high <= pc[10:8]; // [RULE4]
         end
      end
   end

   // sticky stack flags; a pop clears only overflow, a write clears any
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stack_full_flag <= 1'b0;
         stack_overflow_flag <= 1'b0;
         stack_underflow_flag <= 1'b0;
         stack_error_flag <= 1'b0;
      end else if (ce_in) begin
         stack_full_flag <= set_full | (stack_full_flag & ~clr_full & ~err_rst); // [RULE12] [RULE21]
         stack_overflow_flag <= (overflow_ev & ~err_rst) |
            (stack_overflow_flag & ~clr_over & ~pop_eff & ~err_rst); // [RULE15] [RULE19]
         stack_underflow_flag <= (underflow_ev & ~err_rst) |
            (stack_underflow_flag & ~clr_under & ~err_rst); // [RULE14] [RULE17] [RULE18]
         stack_error_flag <= error_ev | (stack_error_flag & ~clr_error); // [RULE17]
      end
   end

   // error reset pulse to the chip reset logic
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         chip_reset_out <= 1'b0;
      end else if (ce_in) begin
         chip_reset_out <= err_rst; // [RULE14] [RULE15]
      end
   end

   // strap is caught once after reset release; no bus path reaches it
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         stack_error_reset_enable <= 1'b0;
         strap_taken <= 1'b0;
      end else if (ce_in && !strap_taken) begin
         stack_error_reset_enable <= stack_error_reset_enable_in; // [RULE16]
         strap_taken <= 1'b1;
      end
   end

   // bus slave: ack one cycle after the request, dropped the next cycle
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= PCS_DATA_RESET;
      end else if (ce_in) begin
         wb_ack_out <= bus_req;
         if (bus_rd) begin
            wb_dat_out <= {24'h00_0000, rd_byte}; // [RULE9]
         end
      end
   end

   // program memory contents: written words only, no reset on the array
   always_ff @(posedge core_clk_in) begin
      if (ce_in && prog_we_in) begin
         main_program_memory[prog_addr_in] <= prog_data_in;
      end
   end

   // written-word map so a blank word reads as all ones
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         prog_done <= '0;
      end else if (ce_in && prog_we_in) begin
         prog_done[prog_addr_in] <= 1'b1;
      end
   end

   // instruction word at the current counter, one cycle behind
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         instr_out <= PCS_BLANK_WORD;
      end else if (ce_in) begin
         instr_out <= prog_done[pc] ? main_program_memory[pc] : PCS_BLANK_WORD; // [RULE2]
      end
   end

   // checks share the core clock; a reset in progress masks them all
   default clocking pcs_cb @(posedge core_clk_in);
   endclocking
   default disable iff (rst_in);

   // a push below the last layer deepens the stack and saves the counter
   chk_push_depth: assert property ( // [RULE7]
      ce_in && do_push && !sp_at_top |=> sp == $past(sp) + 3'h1 && stack_top == $past(pc))
      else $error("push did not raise pointer and store counter");

   // a return with a non-empty stack reloads the counter from the top
   chk_ret_pc: assert property ( // [RULE8]
      ce_in && ret_in && !sp_empty |=> pc == $past(stack_top) && sp == $past(sp) - 3'h1)
      else $error("return did not restore counter and drop pointer");

   // the empty stack must read zero on the bus, never a stale layer
   chk_empty_top: assert property ( // [RULE6]
      ce_in && bus_rd && hit_tsl && sp_empty |=> wb_dat_out == PCS_DATA_RESET)
      else $error("empty stack top not zero");

   // a pop on an empty stack is silent and leaves the pointer at zero
   chk_pop_empty: assert property ( // [RULE13]
      ce_in && do_pop && sp_empty && !clr_under |=> sp_empty && $stable(stack_underflow_flag))
      else $error("pop on empty stack changed pointer or flagged underflow");

   // underflow sends counter and pointer home; the strap trades flag for reset
   chk_underflow_act: assert property ( // [RULE14]
      ce_in && underflow_ev |=> pc == PCS_PC_RESET && sp_empty &&
         ($past(stack_error_reset_enable) ? (chip_reset_out && !stack_underflow_flag)
            : stack_underflow_flag))
      else $error("underflow handling wrong");

   // overflow keeps the pointer on the last layer and overwrites that layer
   chk_overflow_hold: assert property ( // [RULE15]
      ce_in && overflow_ev && !stack_error_reset_enable |=>
         sp_at_top && stack_overflow_flag && stack_top == $past(pc))
      else $error("overflow handling wrong");

   // full comes with the push that fills the last layer; the call still jumps
   chk_full_warn: assert property ( // [RULE12]
      ce_in && set_full |=> stack_full_flag && sp_at_top && pc == $past(push_target_in))
      else $error("full flag not raised ahead of overflow");

   // every stack error sets the error flag; the reset pulse lasts one cycle
   chk_error_pulse: assert property ( // [RULE17]
      ce_in && error_ev |=> stack_error_flag && chip_reset_out == $past(err_rst)
         ##1 (!chip_reset_out || $past(err_rst) || !$past(ce_in)))
      else $error("error flag or reset pulse wrong");

   // the full flag drops only on a software clear or an error reset
   chk_flag_sticky: assert property ( // [RULE21]
      $fell(stack_full_flag) |-> $past(ce_in && (clr_full || err_rst)))
      else $error("full flag cleared itself");

   // a plain fetch steps the counter by one and wraps at the top word
   chk_fetch_step: assert property ( // [RULE22]
      ce_in && fetch_in && !ret_in && !push_in && !wr_pcl |=> pc == $past(pc) + 11'h001)
      else $error("counter did not advance on fetch");

   // a low byte read freezes the high bits for the following high read
   chk_latch_read: assert property ( // [RULE4]
      ce_in && rd_pcl |=> pc_latch_high == $past(pc[10:8]))
      else $error("low byte read did not capture high bits");

   // the high latch takes the written bits and nothing else
   chk_latch_write: assert property ( // [RULE3]
      ce_in && wr_pch |=> pc_latch_high == $past(wb_dat_in[2:0]))
      else $error("high latch write lost");

   // the low byte write commits the latched high bits with the new low byte
   chk_pc_load: assert property ( // [RULE3]
      ce_in && wr_pcl && !ret_in && !push_in |=>
         pc == {$past(pc_latch_high), $past(wb_dat_in[7:0])})
      else $error("counter load from latch pair wrong");

   // stack top reads need no order and return the selected layer
   chk_top_read: assert property ( // [RULE9]
      ce_in && bus_rd && hit_tsl |=> wb_ack_out && wb_dat_out[7:0] == $past(stack_top[7:0]))
      else $error("stack top low read wrong");

   // a pop on a non-empty stack drops the pointer and ends an overflow
   chk_pop_clears: assert property ( // [RULE10] [RULE19]
      ce_in && pop_eff |=> sp == $past(sp) - 3'h1 && !stack_overflow_flag)
      else $error("pop did not drop pointer or clear overflow");

   // overflow stands until a pop, a software clear or an error reset
   chk_over_sticky: assert property ( // [RULE21]
      ce_in && stack_overflow_flag && !clr_over && !pop_eff && !err_rst |=>
         stack_overflow_flag)
      else $error("overflow flag cleared itself");

   // full, overflow and underflow may all stand together after a deep unwind
   chk_flags_together: assert property ( // [RULE18]
      ce_in && underflow_ev && !stack_error_reset_enable && stack_full_flag &&
         stack_overflow_flag && !clr_full && !clr_over |=>
         stack_full_flag && stack_overflow_flag && stack_underflow_flag)
      else $error("stack flags did not stand together");

   // an error reset empties the stack and keeps only the error flag
   chk_err_reset: assert property ( // [RULE17]
      ce_in && err_rst |=> sp_empty && pc == PCS_PC_RESET && stack_error_flag &&
         !stack_full_flag && !stack_overflow_flag && !stack_underflow_flag)
      else $error("error reset did not clear the stack state");

   // a word never written reads back as all ones
   chk_blank_word: assert property ( // [RULE2]
      ce_in && !prog_done[pc] |=> instr_out == PCS_BLANK_WORD)
      else $error("blank program word not all ones");

   // the strap is caught once and then held until the next reset
   chk_strap_fixed: assert property ( // [RULE16]
      strap_taken |=> $stable(stack_error_reset_enable))
      else $error("error reset enable changed after capture");

endmodule

//--- testbench/pc_and_hw_stack_control_tb.sv
// self-checking bench for the program counter and hardware return stack
`timescale 1ns/1ns
module pc_and_hw_stack_control_tb;
   import pcs_pkg::*;
   logic clk, rst, ce, cyc, stb, we, fetch, push, ret, pop, strap, pwe, ack, crst;
   logic [7:0] adr;
   logic [31:0] wdat, rdat, dat_o;
   logic [3:0] sel;
   logic [10:0] target, paddr, pc, prev, th;
   logic [10:0] stk[1:7];
   logic [15:0] pdata, instr, lf;
   logic [15:0] pw[0:2];
   int fails, n_tests, i, sp;

   pcs_core dut (.core_clk_in(clk), .rst_in(rst), .ce_in(ce), .wb_cyc_in(cyc),
      .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat),
      .wb_sel_in(sel), .wb_dat_out(dat_o), .wb_ack_out(ack), .fetch_in(fetch),
      .push_in(push), .push_target_in(target), .ret_in(ret), .pop_in(pop),
      .stack_error_reset_enable_in(strap), .prog_we_in(pwe), .prog_addr_in(paddr),
      .prog_data_in(pdata), .pc_out(pc), .instr_out(instr), .chip_reset_out(crst));

   // free-running 50 MHz clock
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // 16-bit feedback shift register, repeatable stimulus
   function automatic logic [15:0] lfsr(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction

   // expected stack control byte
   function automatic logic [31:0] ctl(input bit f, input bit u, input bit o, input int p);
      return {24'h00_0000, f, u, o, 2'b00, 3'(p)};
   endfunction

   task automatic print_verdict;
      $display("tests %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // classic single cycle; waits for ack with a bound, read data taken at that edge
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      adr <= a;
      we <= w;
      wdat <= d;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (ack !== 1'b1) begin
         fails++;
         print_verdict();
      end
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   // one stack strobe for one enabled edge, outputs checked just after it
   task automatic op(input logic p, input logic r, input logic q, input logic [10:0] t);
      @(posedge clk);
      push <= p;
      ret <= r;
      pop <= q;
      target <= t;
      @(posedge clk);
      push <= 1'b0;
      ret <= 1'b0;
      pop <= 1'b0;
      #1;
   endtask

   // strap is sampled right after release, so stack ops wait two edges
   task automatic do_reset(input logic s);
      rst <= 1'b1;
      strap <= s;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic wait_crst;
      int k;
      for (k = 0; k < 4 && crst !== 1'b1; k++) @(posedge clk);
      chk(crst, 1'b1);
   endtask

   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      print_verdict();
   end

   initial begin
      {rst, ce, cyc, stb, we, fetch, push, ret, pop, strap, pwe} = 11'b110_0000_0000;
      adr = 8'h00;
      wdat = 32'h0000_0000;
      sel = 4'hf;
      target = 11'h000;
      paddr = 11'h000;
      pdata = 16'h0000;
      lf = 16'h0c94;
      fails = 0;
      n_tests = 0;
      do_reset(1'b0);
      chk(pc, PCS_PC_RESET);
      chk(instr, PCS_BLANK_WORD);
      wb(PCS_ADR_CONTROL, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0000);
      wb(PCS_ADR_TOP_LOW, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0000);
      $display("test reset done");
      // three words at the top of memory, the wrap target stays blank
      for (i = 0; i < 3; i++) begin
         lf = lfsr(lf);
         pw[i] = lf;
         @(posedge clk);
         pwe <= 1'b1;
         paddr <= 11'(11'h7fd + i);
         pdata <= lf;
      end
      @(posedge clk);
      pwe <= 1'b0;
      wb(PCS_ADR_PC_HIGH, 1'b1, 32'h7);
      wb(PCS_ADR_PC_LOW, 1'b1, 32'hfd);
      chk(pc, 11'h7fd);
      wb(PCS_ADR_PC_LOW, 1'b0, 32'h0);
      th = {3'h0, rdat[7:0]};
      wb(PCS_ADR_PC_HIGH, 1'b0, 32'h0);
      chk({rdat[2:0], th[7:0]}, 11'h7fd);
      for (i = 0; i < 4; i++) begin
         @(posedge clk);
         #1;
         chk(pc, 11'(11'h7fd + i));
         chk(instr, (i < 3) ? pw[i] : PCS_BLANK_WORD);
         @(posedge clk);
         fetch <= 1'b1;
         @(posedge clk);
         fetch <= 1'b0;
      end
      // a frozen clock enable must hold the counter
      @(posedge clk);
      ce <= 1'b0;
      fetch <= 1'b1;
      repeat (3) @(posedge clk);
      ce <= 1'b1;
      fetch <= 1'b0;
      #1;
      chk(pc, 11'h001);
      $display("test counter done");
      prev = 11'h001;
      for (i = 1; i <= 8; i++) begin
         lf = lfsr(lf);
         sp = (i < 8) ? i : 7;
         stk[sp] = prev;
         op(1'b1, 1'b0, 1'b0, lf[10:0]);
         chk(pc, lf[10:0]);
         prev = lf[10:0];
         wb(PCS_ADR_CONTROL, 1'b0, 32'h0);
         chk(rdat, ctl(i >= 7, 0, i == 8, sp));
         wb(PCS_ADR_TOP_HIGH, 1'b0, 32'h0);
         th = {rdat[2:0], 8'h00};
         wb(PCS_ADR_TOP_LOW, 1'b0, 32'h0);
         chk({th[10:8], rdat[7:0]}, stk[sp]);
      end
      wb(PCS_ADR_STATUS, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0004);
      for (sp = 7; sp >= 1; sp--) begin
         op(1'b0, 1'b1, 1'b0, 11'h000);
         chk(pc, stk[sp]);
         wb(PCS_ADR_CONTROL, 1'b0, 32'h0);
         chk(rdat, ctl(1, 0, 1, sp - 1));
      end
      op(1'b0, 1'b1, 1'b0, 11'h000);
      chk(pc, 11'h000);
      op(1'b0, 1'b0, 1'b1, 11'h000);
      wb(PCS_ADR_CONTROL, 1'b0, 32'h0);
      chk(rdat, ctl(1, 1, 1, 0));
      // a clear without byte lane 0 must not touch the flags
      sel <= 4'he;
      wb(PCS_ADR_CONTROL, 1'b1, 32'he0);
      sel <= 4'hf;
      wb(PCS_ADR_CONTROL, 1'b0, 32'h0);
      chk(rdat, ctl(1, 1, 1, 0));
      wb(PCS_ADR_CONTROL, 1'b1, 32'he0);
      wb(PCS_ADR_CONTROL, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0000);
      op(1'b0, 1'b0, 1'b1, 11'h000);
      wb(PCS_ADR_CONTROL, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0000);
      // layers 1 to 6 hold n-1, layer 7 is overwritten with 7, so one pop past overflow shows 5 on top
      for (i = 1; i <= 8; i++) op(1'b1, 1'b0, 1'b0, 11'(i));
      op(1'b0, 1'b0, 1'b1, 11'h000);
      wb(PCS_ADR_CONTROL, 1'b0, 32'h0);
      chk(rdat, ctl(1, 0, 0, 6));
      wb(PCS_ADR_TOP_LOW, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0005);
      $display("test stack done");
      do_reset(1'b1);
      for (i = 1; i <= 8; i++) op(1'b1, 1'b0, 1'b0, 11'(i + 3));
      wait_crst();
      chk(pc, 11'h000);
      wb(PCS_ADR_CONTROL, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0000);
      wb(PCS_ADR_STATUS, 1'b1, 32'h4);
      wb(PCS_ADR_STATUS, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0000);
      op(1'b0, 1'b1, 1'b0, 11'h000);
      wait_crst();
      wb(PCS_ADR_STATUS, 1'b0, 32'h0);
      chk(rdat, 32'h0000_0004);
      $display("test error reset done");
      print_verdict();
   end
endmodule
